/* File: rtl/dhr_core.sv */
// core-side debug halt/resume sideband logic
//
// Our own choices: the APB slave port and the register offsets.
`default_nettype none
module dhr_core (
  // clock and debug reset
  input wire logic pclk,
  input wire logic presetn,
  // sideband link
  dhr_link_if.core lk,
  // core pipeline events
  input wire logic entry_complete,
  input wire logic barrier_complete,
  input wire logic tx_channel_full,
  input wire logic rx_channel_full,
  // debug register writes
  input wire logic ctrl_wr,
  input wire logic force_acknowledge_wr,
  input wire logic keep_powered_wr,
  input wire logic os_lock_wr,
  input wire logic os_lock_wr_value,
  // register views
  output logic [31:0] debug_status_control_word,
  output logic powered_up_status,
  output logic os_lock,
  output logic in_debug_state,
  output logic system_access_allowed,
  output logic ext_debug_instr_undefined,
  // static configuration views
  output logic [19:0] rom_table_base_out,
  output logic rom_table_base_valid_out,
  output logic [19:0] self_offset_out,
  output logic self_offset_valid_out
);
  // *****************************
  // state
  // *****************************
  typedef struct packed {
    dhr_pkg::dhr_core_state_type st;
    logic [31:0] dsc;
    logic committed;
    logic keep_pwr;
    logic os_lock;
    logic [1:0] init_cnt;
    logic halt_s1;
    logic halt_s2;
    logic resume_s1;
    logic resume_s2;
    logic pwr_s1;
    logic pwr_s2;
    logic lock_s1;
    logic lock_s2;
    logic oslk_s1;
    logic oslk_s2;
    logic [19:0] rom_s1;
    logic [19:0] rom_s2;
    logic romv_s1;
    logic romv_s2;
    logic [19:0] self_s1;
    logic [19:0] self_s2;
    logic selfv_s1;
    logic selfv_s2;
  } dhr_core_reg_type;

  localparam dhr_core_reg_type RESET_VALUE = '{
    st: dhr_pkg::CS_RUN,
    dsc: dhr_pkg::DSC_RESET,
    committed: 1'b0,
    keep_pwr: dhr_pkg::KEEP_PWR_RESET,
    os_lock: dhr_pkg::OS_LOCK_RESET,
    init_cnt: 2'h0,
    rom_s1: 20'h0_0000,
    rom_s2: 20'h0_0000,
    self_s1: 20'h0_0000,
    self_s2: 20'h0_0000,
    default: 1'b0
  };

  dhr_core_reg_type q;
  dhr_core_reg_type d;
  logic force_ack;

  // *****************************
  // next state
  // *****************************
  always_comb
  begin
    d = q;
    // pins from the other chip: first stage feeds only the second
    d.halt_s1 = lk.external_halt_request;
    d.halt_s2 = q.halt_s1;
    d.resume_s1 = lk.resume_request;
    d.resume_s2 = q.resume_s1;
    d.pwr_s1 = lk.powered_up_in;
    d.pwr_s2 = q.pwr_s1;
    d.lock_s1 = lk.debugger_lockout;
    d.lock_s2 = q.lock_s1;
    d.oslk_s1 = lk.os_lock_reset_value;
    d.oslk_s2 = q.oslk_s1;
    d.rom_s1 = lk.rom_table_base;
    d.rom_s2 = q.rom_s1;
    d.romv_s1 = lk.rom_table_base_valid;
    d.romv_s2 = q.romv_s1;
    d.self_s1 = lk.self_offset;
    d.self_s2 = q.self_s1;
    d.selfv_s1 = lk.self_offset_valid;
    d.selfv_s2 = q.selfv_s1;
    // channel flags follow the transfer logic every cycle
    d.dsc[dhr_pkg::DSC_TX_FULL] = tx_channel_full;
    d.dsc[dhr_pkg::DSC_RX_FULL] = rx_channel_full;
    // strap caught once the synchroniser has filled, never at reset itself
    if (q.init_cnt != dhr_pkg::INIT_DONE)
    begin
      d.init_cnt = q.init_cnt + 2'h1;
    end
    if (q.init_cnt == dhr_pkg::INIT_CAPTURE)
    begin
      d.os_lock = q.oslk_s2;
    end
    else if (os_lock_wr)
    begin
      d.os_lock = os_lock_wr_value;
    end
    if (ctrl_wr)
    begin
      d.dsc[dhr_pkg::DSC_FORCE_ACK] = force_acknowledge_wr;
      d.keep_pwr = keep_powered_wr;
    end
    unique case (q.st)
      dhr_pkg::CS_RUN:
      begin
        // commit on the first synchronised sight of the request
        if (q.halt_s2)
        begin
          d.st = dhr_pkg::CS_COMMIT;
          d.committed = 1'b1;
        end
      end
      dhr_pkg::CS_COMMIT:
      begin
        if (entry_complete)
        begin
          d.st = dhr_pkg::CS_HALTED;
          d.dsc[dhr_pkg::DSC_HALTED] = 1'b1;
          d.dsc[dhr_pkg::DSC_METHOD_LO +: dhr_pkg::DSC_METHOD_W] =
            dhr_pkg::METHOD_EXT_HALT;
        end
      end
      dhr_pkg::CS_HALTED:
      begin
        // drained can only follow halted: barrier is looked at here only
        if (barrier_complete)
        begin
          d.dsc[dhr_pkg::DSC_DRAINED] = 1'b1;
        end
        if (q.resume_s2 && q.dsc[dhr_pkg::DSC_RESTARTED])
        begin
          d.dsc[dhr_pkg::DSC_RESTARTED] = 1'b0;
          d.st = dhr_pkg::CS_RESTART;
        end
      end
      dhr_pkg::CS_RESTART:
      begin
        // exit waits for the request to fall, so a held request cannot re-enter
        if (!q.resume_s2)
        begin
          d.st = dhr_pkg::CS_RUN;
          d.committed = 1'b0;
          d.dsc[dhr_pkg::DSC_HALTED] = 1'b0;
          d.dsc[dhr_pkg::DSC_DRAINED] = 1'b0;
          d.dsc[dhr_pkg::DSC_RESTARTED] = 1'b1;
        end
      end
      default:
      begin
        d.st = dhr_pkg::CS_RUN;
      end
    endcase
  end

  // *****************************
  // registers
  // *****************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= RESET_VALUE;
    end
    else
    begin
      q <= d;
    end
  end

  // *****************************
  // outputs
  // *****************************
  assign force_ack = q.dsc[dhr_pkg::DSC_FORCE_ACK];
  assign lk.halt_committed = q.committed | force_ack;
  assign lk.halted_ack = q.dsc[dhr_pkg::DSC_HALTED] | force_ack;
  assign lk.halt_memory_drained = q.dsc[dhr_pkg::DSC_DRAINED] | force_ack;
  assign lk.resume_ack = q.dsc[dhr_pkg::DSC_RESTARTED];
  assign lk.comm_tx_ready = ~q.dsc[dhr_pkg::DSC_TX_FULL];
  assign lk.comm_rx_pending = q.dsc[dhr_pkg::DSC_RX_FULL];
  assign lk.keep_powered_request = q.keep_pwr;
  assign debug_status_control_word = q.dsc;
  assign powered_up_status = q.pwr_s2;
  assign os_lock = q.os_lock;
  assign in_debug_state = q.dsc[dhr_pkg::DSC_HALTED];
  assign system_access_allowed = ~q.lock_s2;
  assign ext_debug_instr_undefined = q.lock_s2;
  assign rom_table_base_out = q.rom_s2;
  assign rom_table_base_valid_out = q.romv_s2;
  assign self_offset_out = q.self_s2;
  assign self_offset_valid_out = q.selfv_s2;
endmodule
`default_nettype wire

/* File: rtl/dhr_ctl.sv */
// system-side controller for the debug halt/resume sideband, APB slave
`default_nettype none
module dhr_ctl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power controller
  output logic power_emulate_mode,
  // sideband link
  dhr_link_if.ctl lk
);
  // *****************************
  // state
  // *****************************
  typedef struct packed {
    dhr_pkg::dhr_resume_state_type rs;
    logic halt_req;
    logic resume_req;
    logic [6:0] ctl;
    logic [19:0] rom;
    logic [19:0] self_off;
    logic [6:0] in_s1;
    logic [6:0] in_s2;
    logic [31:0] rdata;
  } dhr_ctl_reg_type;

  localparam dhr_ctl_reg_type RESET_VALUE = '{
    rs: dhr_pkg::RS_IDLE,
    halt_req: 1'b0,
    resume_req: 1'b0,
    ctl: dhr_pkg::CTL_RESET,
    rom: 20'h0_0000,
    self_off: 20'h0_0000,
    in_s1: 7'h00,
    in_s2: 7'h00,
    rdata: 32'h0000_0000
  };

  dhr_ctl_reg_type q;
  dhr_ctl_reg_type d;
  logic wr;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == dhr_pkg::CTL_OFF) || (a == dhr_pkg::STAT_OFF) ||
                (a == dhr_pkg::ROM_OFF) || (a == dhr_pkg::SELF_OFF);
  endfunction

  assign wr = psel && penable && pwrite && is_mapped(paddr);

  // *****************************
  // next state
  // *****************************
  always_comb
  begin
    d = q;
    d.in_s1 = {lk.keep_powered_request, lk.comm_tx_ready, lk.comm_rx_pending, lk.resume_ack,
               lk.halt_memory_drained, lk.halted_ack, lk.halt_committed};
    d.in_s2 = q.in_s1;
    // halt request held until either acknowledge is seen
    if (q.halt_req && (q.in_s2[0] || q.in_s2[1]))
    begin
      d.halt_req = 1'b0;
    end
    unique case (q.rs)
      dhr_pkg::RS_IDLE:
      begin
      end
      dhr_pkg::RS_WAIT:
      begin
        if (q.in_s2[3])
        begin
          d.resume_req = 1'b1;
          d.rs = dhr_pkg::RS_HOLD;
        end
      end
      dhr_pkg::RS_HOLD:
      begin
        if (!q.in_s2[3])
        begin
          d.resume_req = 1'b0;
          d.rs = dhr_pkg::RS_IDLE;
        end
      end
      default:
      begin
        d.rs = dhr_pkg::RS_IDLE;
      end
    endcase
    if (wr)
    begin
      unique case (paddr)
        dhr_pkg::CTL_OFF:
        begin
          d.ctl = pwdata[dhr_pkg::CTL_W-1:0];
          d.ctl[dhr_pkg::CTL_HALT_GO] = 1'b0;
          d.ctl[dhr_pkg::CTL_RESUME_GO] = 1'b0;
          // go bits are ignored while busy or, for halt, while already committed
          if (pwdata[dhr_pkg::CTL_HALT_GO] && !q.halt_req && !q.in_s2[0])
          begin
            d.halt_req = 1'b1;
          end
          if (pwdata[dhr_pkg::CTL_RESUME_GO] && (q.rs == dhr_pkg::RS_IDLE) && q.in_s2[1])
          begin
            d.rs = dhr_pkg::RS_WAIT;
          end
        end
        dhr_pkg::ROM_OFF:
        begin
          d.rom = pwdata[dhr_pkg::BASE_LSB +: dhr_pkg::BASE_W];
        end
        dhr_pkg::SELF_OFF:
        begin
          d.self_off = pwdata[dhr_pkg::BASE_LSB +: dhr_pkg::BASE_W];
        end
        default:
        begin
        end
      endcase
    end
    // read data captured in the setup cycle, presented in the access cycle
    if (psel && !penable)
    begin
      d.rdata = 32'h0000_0000;
      unique case (paddr)
        dhr_pkg::CTL_OFF: d.rdata[dhr_pkg::CTL_W-1:0] = q.ctl;
        dhr_pkg::STAT_OFF:
        begin
          d.rdata[dhr_pkg::ST_IN_W-1:0] = q.in_s2;
          d.rdata[dhr_pkg::ST_HALT_BUSY] = q.halt_req;
          d.rdata[dhr_pkg::ST_RESUME_BUSY] = (q.rs != dhr_pkg::RS_IDLE);
        end
        dhr_pkg::ROM_OFF: d.rdata[dhr_pkg::BASE_LSB +: dhr_pkg::BASE_W] = q.rom;
        dhr_pkg::SELF_OFF: d.rdata[dhr_pkg::BASE_LSB +: dhr_pkg::BASE_W] = q.self_off;
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // *****************************
  // registers
  // *****************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= RESET_VALUE;
    end
    else
    begin
      q <= d;
    end
  end

  // *****************************
  // outputs
  // *****************************
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign power_emulate_mode = q.in_s2[6];
  assign lk.external_halt_request = q.halt_req;
  assign lk.resume_request = q.resume_req;
  assign lk.powered_up_in = q.ctl[dhr_pkg::CTL_PWRUP];
  assign lk.os_lock_reset_value = q.ctl[dhr_pkg::CTL_OSLOCK];
  assign lk.debugger_lockout = q.ctl[dhr_pkg::CTL_LOCKOUT];
  assign lk.rom_table_base = q.rom;
  assign lk.rom_table_base_valid = q.ctl[dhr_pkg::CTL_ROM_V];
  assign lk.self_offset = q.self_off;
  assign lk.self_offset_valid = q.ctl[dhr_pkg::CTL_SELF_V];
endmodule
`default_nettype wire

/* File: rtl/dhr_link_if.sv */
// sideband wires between the core debug logic and the system controller
`default_nettype none
interface dhr_link_if;
  logic external_halt_request;
  logic resume_request;
  logic halt_committed;
  logic halted_ack;
  logic halt_memory_drained;
  logic resume_ack;
  logic comm_rx_pending;
  logic comm_tx_ready;
  logic keep_powered_request;
  logic powered_up_in;
  logic os_lock_reset_value;
  logic [19:0] rom_table_base;
  logic rom_table_base_valid;
  logic [19:0] self_offset;
  logic self_offset_valid;
  logic debugger_lockout;
  modport core (
    input external_halt_request, resume_request, powered_up_in, os_lock_reset_value,
    input rom_table_base, rom_table_base_valid, self_offset, self_offset_valid,
    input debugger_lockout,
    output halt_committed, halted_ack, halt_memory_drained, resume_ack,
    output comm_rx_pending, comm_tx_ready, keep_powered_request
  );
  modport ctl (
    output external_halt_request, resume_request, powered_up_in, os_lock_reset_value,
    output rom_table_base, rom_table_base_valid, self_offset, self_offset_valid,
    output debugger_lockout,
    input halt_committed, halted_ack, halt_memory_drained, resume_ack,
    input comm_rx_pending, comm_tx_ready, keep_powered_request
  );
endinterface
`default_nettype wire

/* File: rtl/dhr_pkg.sv */
// shared constants and types for the debug halt/resume sideband
`default_nettype none
package dhr_pkg;
  // *****************************
  // status/control word layout
  // *****************************
  localparam int DSC_HALTED = 0;
  localparam int DSC_RESTARTED = 1;
  localparam int DSC_METHOD_LO = 2;
  localparam int DSC_METHOD_W = 4;
  localparam int DSC_FORCE_ACK = 10;
  localparam int DSC_DRAINED = 19;
  localparam int DSC_TX_FULL = 29;
  localparam int DSC_RX_FULL = 30;
  localparam logic [3:0] METHOD_EXT_HALT = 4'h4;
  localparam logic [31:0] DSC_RESET = 32'h0000_0002;
  // *****************************
  // reset values, timing and base field position
  // *****************************
  localparam logic OS_LOCK_RESET = 1'b1;
  localparam logic KEEP_PWR_RESET = 1'b0;
  localparam logic [1:0] INIT_CAPTURE = 2'h2;
  localparam logic [1:0] INIT_DONE = 2'h3;
  localparam int BASE_LSB = 12;
  localparam int BASE_W = 20;
  // *****************************
  // controller register map
  // *****************************
  localparam int APB_AW = 12;
  localparam logic [11:0] CTL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] ROM_OFF = 12'h008;
  localparam logic [11:0] SELF_OFF = 12'h00C;
  localparam int CTL_HALT_GO = 0;
  localparam int CTL_RESUME_GO = 1;
  localparam int CTL_PWRUP = 2;
  localparam int CTL_OSLOCK = 3;
  localparam int CTL_LOCKOUT = 4;
  localparam int CTL_ROM_V = 5;
  localparam int CTL_SELF_V = 6;
  localparam int CTL_W = 7;
  localparam logic [6:0] CTL_RESET = 7'h1C;
  localparam int ST_IN_W = 7;
  localparam int ST_HALT_BUSY = 7;
  localparam int ST_RESUME_BUSY = 8;
  // *****************************
  // state encodings
  // *****************************
  typedef enum logic [3:0] {
    CS_RUN = 4'b0001,
    CS_COMMIT = 4'b0010,
    CS_HALTED = 4'b0100,
    CS_RESTART = 4'b1000
  } dhr_core_state_type;
  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_WAIT = 3'b010,
    RS_HOLD = 3'b100
  } dhr_resume_state_type;
endpackage
`default_nettype wire

/* File: tb/dhr_props.sv */
// concurrent checks on the halt/resume sideband link
`default_nettype none
module dhr_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link signals
  input wire logic external_halt_request,
  input wire logic resume_request,
  input wire logic halt_committed,
  input wire logic halted_ack,
  input wire logic halt_memory_drained,
  input wire logic resume_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // *****************************
  // resume steps
  // *****************************
  // two sync flops plus one state edge bound both waits
  sequence ack_drop_s;
    ##[1:3] !resume_ack;
  endsequence
  sequence exit_s;
    ##[1:3] (resume_ack && !halted_ack && !halt_committed && !halt_memory_drained);
  endsequence
  // *****************************
  // halt entry
  // *****************************
  commit_first_a: assert property ($rose(halted_ack) |-> halt_committed)
    else $error("halted ack rose before commit");
  drain_last_a: assert property ($rose(halt_memory_drained) |-> halted_ack && halt_committed)
    else $error("drained rose out of order");
  commit_soon_a: assert property ($rose(external_halt_request) |-> ##[1:3] halt_committed)
    else $error("commit late after halt request");
  halt_hold_a: assert property (external_halt_request && !halt_committed && !halted_ack
    |=> external_halt_request)
    else $error("halt request dropped before ack");
  halt_drop_a: assert property ($fell(external_halt_request) |-> halt_committed || halted_ack)
    else $error("halt request dropped without ack");
  // *****************************
  // resume handshake
  // *****************************
  resume_start_a: assert property ($rose(resume_request) |-> resume_ack)
    else $error("resume request raised while ack low");
  resume_hold_a: assert property (resume_request && resume_ack |=> resume_request)
    else $error("resume request dropped before ack fell");
  ack_drop_a: assert property ($rose(resume_request) |-> ack_drop_s)
    else $error("resume ack did not fall");
  exit_clear_a: assert property ($fell(resume_request) |-> exit_s)
    else $error("exit did not clear acks and restore resume ack");
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// directed testbench joining core and controller over the sideband link
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic power_emulate_mode;
  logic entry_complete = 1'b0;
  logic barrier_complete = 1'b0;
  logic tx_full = 1'b0;
  logic rx_full = 1'b0;
  logic ctrl_wr = 1'b0;
  logic force_wr = 1'b0;
  logic keep_wr = 1'b0;
  // second reset for the core side only, so the strap can be seen low
  logic dbg_rst_n = 1'b1;
  logic [31:0] status_word;
  logic pwr_status, os_lock, in_debug, allowed, undef, rom_v, self_v;
  logic [19:0] rom_out, self_out;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  dhr_link_if lk ();
  always #2 pclk = ~pclk;
  dhr_core u_dhr_core (.pclk(pclk), .presetn(presetn & dbg_rst_n), .lk(lk),
    .entry_complete(entry_complete), .barrier_complete(barrier_complete),
    .tx_channel_full(tx_full), .rx_channel_full(rx_full), .ctrl_wr(ctrl_wr),
    .force_acknowledge_wr(force_wr), .keep_powered_wr(keep_wr),
    .os_lock_wr(1'b0), .os_lock_wr_value(1'b0),
    .debug_status_control_word(status_word), .powered_up_status(pwr_status),
    .os_lock(os_lock), .in_debug_state(in_debug), .system_access_allowed(allowed),
    .ext_debug_instr_undefined(undef), .rom_table_base_out(rom_out),
    .rom_table_base_valid_out(rom_v), .self_offset_out(self_out),
    .self_offset_valid_out(self_v));
  dhr_ctl u_dhr_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_emulate_mode(power_emulate_mode), .lk(lk));
  dhr_props u_dhr_props (.pclk(pclk), .presetn(presetn & dbg_rst_n),
    .external_halt_request(lk.external_halt_request), .resume_request(lk.resume_request),
    .halt_committed(lk.halt_committed), .halted_ack(lk.halted_ack),
    .halt_memory_drained(lk.halt_memory_drained), .resume_ack(lk.resume_ack));
  // *****************************
  // shared tasks
  // *****************************
  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // waits on pready with no assumed latency; the run timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // *****************************
  // scenarios
  // *****************************
  task automatic t_reset();
    apb(1'h0, dhr_pkg::CTL_OFF, 32'h0000_0000);
    chk("ctl", 32'h0000_001C, rd);
    apb(1'h0, dhr_pkg::STAT_OFF, 32'h0000_0000);
    chk("stat", 32'h0000_0028, rd);
    chk("status word", 32'h0000_0002, status_word);
    chk("os lock", 1'h1, os_lock);
    chk("undefined", 1'h1, undef);
    chk("allowed", 1'h0, allowed);
    chk("powered", 1'h1, pwr_status);
  endtask
  task automatic t_halt();
    apb(1'h1, dhr_pkg::CTL_OFF, 32'h0000_001D);
    for (int i = 0; i < 16 && lk.halt_committed !== 1'b1; i++) @(posedge pclk);
    chk("committed", 1'h1, lk.halt_committed);
    repeat (4) @(posedge pclk);
    chk("halted early", 1'h0, lk.halted_ack);
    entry_complete <= 1'b1;
    for (int i = 0; i < 16 && lk.halted_ack !== 1'b1; i++) @(posedge pclk);
    entry_complete <= 1'b0;
    chk("halted", 1'h1, lk.halted_ack);
    chk("bit0", 1'h1, status_word[0]);
    chk("in debug", 1'h1, in_debug);
    chk("method", 4'h4, status_word[5:2]);
    chk("drained early", 1'h0, lk.halt_memory_drained);
    chk("halt req", 1'h0, lk.external_halt_request);
    barrier_complete <= 1'b1;
    for (int i = 0; i < 16 && lk.halt_memory_drained !== 1'b1; i++) @(posedge pclk);
    barrier_complete <= 1'b0;
    chk("drained", 1'h1, lk.halt_memory_drained);
    chk("bit19", 1'h1, status_word[19]);
    repeat (3) @(posedge pclk);
    apb(1'h0, dhr_pkg::STAT_OFF, 32'h0000_0000);
    chk("stat halted", 32'h0000_002F, rd & 32'h0000_007F);
  endtask
  task automatic t_resume();
    apb(1'h1, dhr_pkg::CTL_OFF, 32'h0000_001E);
    for (int i = 0; i < 16 && lk.resume_ack !== 1'b0; i++) @(posedge pclk);
    chk("ack low", 1'h0, lk.resume_ack);
    for (int i = 0; i < 16 && lk.resume_ack !== 1'b1; i++) @(posedge pclk);
    chk("ack high", 1'h1, lk.resume_ack);
    chk("acks", 3'h0, {lk.halt_committed, lk.halted_ack, lk.halt_memory_drained});
    chk("restarted", 2'h2, status_word[1:0]);
  endtask
  task automatic t_force();
    ctrl_wr <= 1'b1;
    force_wr <= 1'b1;
    keep_wr <= 1'b1;
    @(posedge pclk);
    ctrl_wr <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("forced", 3'h7, {lk.halt_committed, lk.halted_ack, lk.halt_memory_drained});
    chk("bit10", 1'h1, status_word[10]);
    chk("keep", 1'h1, lk.keep_powered_request);
    repeat (3) @(posedge pclk);
    chk("emulate", 1'h1, power_emulate_mode);
    ctrl_wr <= 1'b1;
    force_wr <= 1'b0;
    keep_wr <= 1'b0;
    @(posedge pclk);
    ctrl_wr <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("unforced", 3'h0, {lk.halt_committed, lk.halted_ack, lk.halt_memory_drained});
    chk("keep off", 1'h0, lk.keep_powered_request);
  endtask
  task automatic t_comm();
    tx_full <= 1'b1;
    rx_full <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("tx full", 1'h0, lk.comm_tx_ready);
    chk("rx full", 1'h1, lk.comm_rx_pending);
    tx_full <= 1'b0;
    rx_full <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("tx empty", 1'h1, lk.comm_tx_ready);
    chk("rx empty", 1'h0, lk.comm_rx_pending);
  endtask
  task automatic t_cfg();
    apb(1'h1, dhr_pkg::ROM_OFF, 32'hABCD_E000);
    apb(1'h1, dhr_pkg::SELF_OFF, 32'hFFFF_F000);
    apb(1'h1, dhr_pkg::CTL_OFF, 32'h0000_0060);
    repeat (4) @(posedge pclk);
    chk("rom", 21'h1A_BCDE, {rom_v, rom_out});
    chk("self", 21'h1F_FFFF, {self_v, self_out});
    chk("powered", 1'h0, pwr_status);
    chk("unlocked", 2'h2, {allowed, undef});
    apb(1'h0, 12'h010, 32'h0000_0000);
    chk("unmapped err", 1'h1, err);
    chk("unmapped data", 32'h0000_0000, rd);
  endtask
  // core-only reset after the strap was written low
  task automatic t_oslock();
    dbg_rst_n <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("os lock in reset", 1'h1, os_lock);
    chk("word in reset", 32'h0000_0002, status_word);
    dbg_rst_n <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("os lock strap low", 1'h0, os_lock);
    chk("acks after reset", 4'h1, {lk.halt_committed, lk.halted_ack,
      lk.halt_memory_drained, lk.resume_ack});
  endtask
  // *****************************
  // main sequence and timeout
  // *****************************
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_halt();
    t_resume();
    t_force();
    t_comm();
    t_cfg();
    t_oslock();
    print_verdict();
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
endmodule
`default_nettype wire
